// *** shared/bgs_map.svh ***
// Purpose: offsets, field positions, reset values and limits of the gauge
// Assumes: byte addresses on a 32-bit register bus, one word per register
// Notes:   definitions only
`ifndef BGS_MAP_SVH
`define BGS_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BGS_OFS_FLAG_ONE  8'h00
`define BGS_OFS_FLAG_TWO  8'h04
`define BGS_OFS_TMPGAUGE  8'h08
`define BGS_OFS_NAC       8'h0C
`define BGS_OFS_LFD       8'h10
`define BGS_OFS_FULLCNT   8'h14
`define BGS_OFS_CICNT     8'h18
`define BGS_OFS_BATT_ID   8'h1C
`define BGS_OFS_CMD       8'h20
`define BGS_OFS_PROG      8'h24
`define BGS_OFS_EDV_TH    8'h28
`define BGS_OFS_FIRST_EMPTY_THRESHOLD_TH   8'h2C
`define BGS_OFS_OVL_TH    8'h30

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BGS_F1_EDV        1
`define BGS_F1_VDQ        3
`define BGS_F1_CI         4
`define BGS_F1_BRM        5
`define BGS_F1_BRP        6
`define BGS_F1_CHG        7
`define BGS_F2_OVL        0
`define BGS_F2_CR         7
`define BGS_CMD_INIT      0

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define BGS_RST_LFD       8'h40
`define BGS_RST_EDV_TH    12'h300
`define BGS_RST_FIRST_EMPTY_THRESHOLD_TH   12'h320
`define BGS_RST_OVL_TH    12'h200
`define BGS_RST_BATT_ID   8'h05
`define BGS_CI_LIMIT      8'h40
`define BGS_PFC_LOW       8'h40
`define BGS_PFC_FLOAT     8'h80
`define BGS_PFC_HIGH      8'hC0

`endif

// *** shared/bgs_pkg.sv ***
// Purpose: types shared by the gauge modules
// Assumes: nothing
// Notes:   constants live in bgs_map.svh
package bgs_pkg;

    typedef enum logic [1:0] {
        LVL_LOW   = 2'b00,
        LVL_FLOAT = 2'b01,
        LVL_HIGH  = 2'b10
    } bgs_lvl_t;

    typedef enum logic {
        BUS_IDLE   = 1'b0,
        BUS_RDWAIT = 1'b1
    } bgs_bus_st_t;

endpackage : bgs_pkg

// *** shared/bgs_reg_if.sv ***
// Purpose: register access carrier between bus slave and gauge core
// Assumes: one write strobe per cycle, read address held for a cycle
// Notes:   rdata is combinational from raddr
`timescale 1ns/1ps
`default_nettype none

interface bgs_reg_if;
    logic        wr;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [7:0]  raddr;
    logic [31:0] rdata;

    modport slave (output wr, waddr, wdata, raddr, input rdata);
    modport core  (input wr, waddr, wdata, raddr, output rdata);
endinterface : bgs_reg_if

`default_nettype wire

// *** design/bgs_ahb_slave.sv ***
// Purpose: AHB-Lite slave front end of the gauge registers
// Assumes: single word transfers, one slave on the bus
// Notes:   writes take no wait state, reads take one
`timescale 1ns/1ps
`default_nettype none

module bgs_ahb_slave
    import bgs_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic [31:0] hrdata,
    // core side
    bgs_reg_if.slave         regs
);
    bgs_bus_st_t st_q;
    logic        wpend_q;
    logic [7:0]  addr_q;
    logic        take;

    assign take = hsel & htrans[1] & hready;

    // ----------------------------------------------------------------
    // address phase capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            addr_q  <= 8'h00;
            wpend_q <= 1'b0;
        end
        else if (hready)
        begin
            wpend_q <= take & hwrite;
            if (take)
                addr_q <= haddr[7:0];
        end
    end

    // the extra read cycle lets a write in the same edge settle first
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q      <= BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            unique case (st_q)
                BUS_IDLE:
                begin
                    if (take && !hwrite)
                    begin
                        st_q      <= BUS_RDWAIT;
                        hreadyout <= 1'b0;
                    end
                end
                BUS_RDWAIT:
                begin
                    st_q      <= BUS_IDLE;
                    hreadyout <= 1'b1;
                    hrdata    <= regs.rdata;
                end
            endcase
        end
    end

    assign regs.wr    = wpend_q;
    assign regs.waddr = addr_q;
    assign regs.wdata = hwdata;
    assign regs.raddr = addr_q;

endmodule : bgs_ahb_slave

`default_nettype wire

// *** design/bgs_pin_sampler.sv ***
// Purpose: catches the programming pins after reset and on init
// Assumes: pin senses are synchronous and settled before release
// Notes:   the three-level pin is read once with pull-up, once pull-down
`timescale 1ns/1ps
`default_nettype none

module bgs_pin_sampler
    import bgs_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // request a fresh sample
    input  wire logic resample,
    // pins
    input  wire logic pfc_pu_sense,
    input  wire logic pfc_pd_sense,
    input  wire logic display_mode_pin,
    // sampled settings
    output var  bgs_lvl_t pfc_level,
    output var  logic     display_abs
);
    logic armed_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            armed_q     <= 1'b1;
            pfc_level   <= LVL_LOW;
            display_abs <= 1'b0;
        end
        else if (armed_q || resample)
        begin
            armed_q     <= 1'b0;
            display_abs <= display_mode_pin;
            // a floating pin follows whichever pull is applied
            if (pfc_pu_sense && pfc_pd_sense)
                pfc_level <= LVL_HIGH;
            else if (!pfc_pu_sense && !pfc_pd_sense)
                pfc_level <= LVL_LOW;
            else
                pfc_level <= LVL_FLOAT;
        end
    end

endmodule : bgs_pin_sampler

`default_nettype wire

// *** design/bgs_gauge_top.sv ***
// Purpose: flag, counter and gauge logic of a battery gauge
// Assumes: analog front end delivers codes and count pulses in clk_sys
// Notes:   registers reached over AHB-Lite, see bgs_map.svh for offsets
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "bgs_map.svh"

// Behaviour
// - latch empty flag when voltage below threshold
// - empty flag clears once charging is seen
// - removed flag set on removal, cleared on return
// - replaced flag set when valid returns after removal
// - replaced flag clears at first threshold or full
// - init command sets replaced flag
// - inaccurate flag after 64 cycles without update
// - count cycles, zero on valid capacity update
// - valid-discharge set when charged to full reference
// - gauge step 0..15 in low four bits
// - full count increments on valid full reach
// - host write of charge count disqualifies update
// - programming pins sampled at reset and on init command
// - full count pin decoded low, float, high
// - overload when sense voltage exceeds threshold
// - charge rate bit kept in second flags
// - display mode picks relative or absolute reference
// - battery id byte written by host, retained
// - host init command reinitialises the gauge
module bgs_gauge_top
    import bgs_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    // measurement front end
    input  wire logic [11:0] vbat_code,
    input  wire logic [11:0] vsr_code,
    input  wire logic        charge_active,
    input  wire logic        charge_fast,
    input  wire logic [2:0]  dsg_rate,
    input  wire logic        batt_valid,
    input  wire logic [3:0]  temp_step,
    input  wire logic        nac_up,
    input  wire logic        nac_down,
    // programming pins
    input  wire logic        pfc_pu_sense,
    input  wire logic        pfc_pd_sense,
    input  wire logic        display_mode_pin,
    // status out
    output var  logic [3:0]  gauge_step,
    output var  logic        overload,
    output var  logic        empty_voltage_flag
);
    bgs_reg_if regs ();

    bgs_lvl_t    pfc_level;
    logic        display_abs;
    logic [7:0]  nac_q;
    logic [7:0]  lfd_q;
    logic [7:0]  full_cnt_q;
    logic [7:0]  ci_cnt_q;
    logic [7:0]  batt_id_q;
    logic [11:0] edv_th_q;
    logic [11:0] first_empty_threshold_th_q;
    logic [11:0] ovl_th_q;
    logic        brm_q;
    logic        brp_q;
    logic        vdq_q;
    logic        init_q;
    logic        wr_nac;
    logic        reach;
    logic        ci_flag;
    logic [7:0]  pfc_cnt;
    logic [7:0]  ref_cnt;
    logic [11:0] ratio;
    logic [7:0]  flag_one;
    logic [7:0]  flag_two;

    // ----------------------------------------------------------------
    // sub blocks
    // ----------------------------------------------------------------
    bgs_ahb_slave u_slave (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .regs      (regs.slave)
    );

    bgs_pin_sampler u_pins (
        .clk_sys          (clk_sys),
        .resetn           (resetn),
        .resample         (init_q),
        .pfc_pu_sense     (pfc_pu_sense),
        .pfc_pd_sense     (pfc_pd_sense),
        .display_mode_pin (display_mode_pin),
        .pfc_level        (pfc_level),
        .display_abs      (display_abs)
    );

    // only whole words are used; hsize is not checked
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    assign wr_nac = regs.wr && regs.waddr == `BGS_OFS_NAC;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            init_q <= 1'b0;
        else
            init_q <= regs.wr && regs.waddr == `BGS_OFS_CMD
                      && regs.wdata[`BGS_CMD_INIT];
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            lfd_q     <= `BGS_RST_LFD;
            batt_id_q <= `BGS_RST_BATT_ID;
            edv_th_q  <= `BGS_RST_EDV_TH;
            first_empty_threshold_th_q <= `BGS_RST_FIRST_EMPTY_THRESHOLD_TH;
            ovl_th_q  <= `BGS_RST_OVL_TH;
        end
        else if (regs.wr)
        begin
            unique case (regs.waddr)
                `BGS_OFS_LFD:     lfd_q     <= regs.wdata[7:0];
                `BGS_OFS_BATT_ID: batt_id_q <= regs.wdata[7:0];
                `BGS_OFS_EDV_TH:  edv_th_q  <= regs.wdata[11:0];
                `BGS_OFS_FIRST_EMPTY_THRESHOLD_TH: first_empty_threshold_th_q <= regs.wdata[11:0];
                `BGS_OFS_OVL_TH:  ovl_th_q  <= regs.wdata[11:0];
                default:          ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // available charge count
    // ----------------------------------------------------------------
    // a count up that lands exactly on the full reference
    assign reach = nac_up && !nac_down && !wr_nac && !init_q
                   && nac_q == 8'(lfd_q - 8'h01) && lfd_q != 8'h00;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            nac_q <= 8'h00;
        else if (init_q)
            nac_q <= 8'h00;
        else if (wr_nac)
            nac_q <= regs.wdata[7:0];
        else if (nac_up && !nac_down && nac_q < lfd_q)
            nac_q <= 8'(nac_q + 8'h01);
        else if (nac_down && !nac_up && nac_q != 8'h00)
            nac_q <= 8'(nac_q - 8'h01);
    end

    // ----------------------------------------------------------------
    // empty-voltage latch
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            empty_voltage_flag <= 1'b0;
        else if (vbat_code < edv_th_q)
            empty_voltage_flag <= 1'b1;
        else if (charge_active)
            empty_voltage_flag <= 1'b0;
    end

    // ----------------------------------------------------------------
    // removed and replaced flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            brm_q <= 1'b0;
        else if (!batt_valid)
            brm_q <= 1'b1;
        else
            brm_q <= 1'b0;
    end

    // set wins over the clear conditions
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            brp_q <= 1'b0;
        else if (init_q)
            brp_q <= 1'b1;
        else if (batt_valid && brm_q)
            brp_q <= 1'b1;
        else if (vbat_code < first_empty_threshold_th_q || reach)
            brp_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // valid discharge, full count, inaccuracy count
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            vdq_q <= 1'b0;
        else if (init_q || wr_nac)
            vdq_q <= 1'b0;
        else if (reach)
            vdq_q <= 1'b1;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            full_cnt_q <= 8'h00;
        else if (reach && vdq_q && full_cnt_q != 8'hFF)
            full_cnt_q <= 8'(full_cnt_q + 8'h01);
    end

    // counter saturates so the flag cannot wrap back to clear
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            ci_cnt_q <= 8'h00;
        else if (init_q)
            ci_cnt_q <= 8'h00;
        else if (reach && vdq_q)
            ci_cnt_q <= 8'h00;
        else if (reach && ci_cnt_q != 8'hFF)
            ci_cnt_q <= 8'(ci_cnt_q + 8'h01);
    end

    assign ci_flag = ci_cnt_q >= `BGS_CI_LIMIT;

    // ----------------------------------------------------------------
    // gauge step and overload
    // ----------------------------------------------------------------
    always_comb
    begin
        unique case (pfc_level)
            LVL_LOW:   pfc_cnt = `BGS_PFC_LOW;
            LVL_FLOAT: pfc_cnt = `BGS_PFC_FLOAT;
            LVL_HIGH:  pfc_cnt = `BGS_PFC_HIGH;
            default:   pfc_cnt = `BGS_PFC_LOW;
        endcase
    end

    assign ref_cnt = display_abs ? pfc_cnt : lfd_q;
    // divider is combinational; one clock is ample at this rate
    assign ratio = (ref_cnt == 8'h00) ? 12'h000
                 : 12'({nac_q, 4'h0} / {4'h0, ref_cnt});

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            gauge_step <= 4'h0;
        else if (ratio > 12'h00F)
            gauge_step <= 4'hF;
        else
            gauge_step <= ratio[3:0];
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            overload <= 1'b0;
        else
            overload <= vsr_code > ovl_th_q;
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        flag_one = 8'h00;
        flag_one[`BGS_F1_EDV] = empty_voltage_flag;
        flag_one[`BGS_F1_VDQ] = vdq_q;
        flag_one[`BGS_F1_CI]  = ci_flag;
        flag_one[`BGS_F1_BRM] = brm_q;
        flag_one[`BGS_F1_BRP] = brp_q;
        flag_one[`BGS_F1_CHG] = charge_active;
        flag_two = {charge_fast, dsg_rate, 4'h0};
        flag_two[`BGS_F2_OVL] = overload;
    end

    always_comb
    begin
        regs.rdata = 32'h0000_0000;
        unique case (regs.raddr)
            `BGS_OFS_FLAG_ONE: regs.rdata[7:0] = flag_one;
            `BGS_OFS_FLAG_TWO: regs.rdata[7:0] = flag_two;
            `BGS_OFS_TMPGAUGE: regs.rdata[7:0] = {temp_step, gauge_step};
            `BGS_OFS_NAC:      regs.rdata[7:0] = nac_q;
            `BGS_OFS_LFD:      regs.rdata[7:0] = lfd_q;
            `BGS_OFS_FULLCNT:  regs.rdata[7:0] = full_cnt_q;
            `BGS_OFS_CICNT:    regs.rdata[7:0] = ci_cnt_q;
            `BGS_OFS_BATT_ID:  regs.rdata[7:0] = batt_id_q;
            `BGS_OFS_PROG:     regs.rdata[2:0] = {display_abs, pfc_level};
            `BGS_OFS_EDV_TH:   regs.rdata[11:0] = edv_th_q;
            `BGS_OFS_FIRST_EMPTY_THRESHOLD_TH:  regs.rdata[11:0] = first_empty_threshold_th_q;
            `BGS_OFS_OVL_TH:   regs.rdata[11:0] = ovl_th_q;
            default:           regs.rdata = 32'h0000_0000;
        endcase
    end

endmodule : bgs_gauge_top

`default_nettype wire

// *** sim/bgs_gauge_props.sv ***
// Purpose: port-level checks of the gauge top
// Assumes: one clock, reset async and active low
// Notes:   bound to every bgs_gauge_top instance
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module bgs_gauge_props
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // front end and status
    input wire logic [11:0] vbat_code,
    input wire logic [11:0] vsr_code,
    input wire logic        charge_active,
    input wire logic        overload,
    input wire logic        empty_voltage_flag
);
    logic take;
    assign take = hsel & htrans[1] & hready;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_resp_okay: assert property (hresp == 1'h0)
        else $error("response not okay");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_fast: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_holds: assert property (hreadyout && !(take && !hwrite)
        |=> $stable(hrdata))
        else $error("read data moved");
    a_empty_latch: assert property (empty_voltage_flag && !charge_active
        |=> empty_voltage_flag)
        else $error("empty flag dropped");
    a_empty_clear: assert property (charge_active && vbat_code == 12'hFFF
        |=> !empty_voltage_flag)
        else $error("empty flag kept");
    a_empty_cause: assert property ($rose(empty_voltage_flag)
        |-> $past(vbat_code) != 12'hFFF)
        else $error("empty flag set at full voltage");
    a_ovl_zero: assert property (vsr_code == 12'h000 ##1 vsr_code == 12'h000
        |=> !overload)
        else $error("overload at zero sense");

    c_read: cover property (take && !hwrite);
    c_empty: cover property ($rose(empty_voltage_flag));
    c_ovl: cover property ($rose(overload));
endmodule : bgs_gauge_props

bind bgs_gauge_top bgs_gauge_props i_props (.clk_sys, .resetn, .hsel,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .vbat_code,
    .vsr_code, .charge_active, .overload, .empty_voltage_flag);

`default_nettype wire

// *** sim/bgs_host_model.sv ***
// Purpose: bus master in place of the host
// Assumes: tasks are entered just after a rising edge
// Notes:   a stuck slave ends the run as a failure
`timescale 1ns/1ps
`default_nettype none

module bgs_host_model
(
    // clock
    input  wire logic        clk_sys,
    // bus
    output var  logic        hsel = 1'h0,
    output var  logic [31:0] haddr = 32'h0,
    output var  logic [1:0]  htrans = 2'h0,
    output var  logic        hwrite = 1'h0,
    output var  logic [31:0] hwdata = 32'h0,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    // bounded so a dead slave cannot hang the run
    task automatic wait_ready();
        int n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hready !== 1'h1 && n < 64);
        if (hready !== 1'h1)
        begin
            bgs_gauge_top_tb.n_fail++;
            bgs_gauge_top_tb.complete_run();
        end
    endtask : wait_ready

    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : access
endmodule : bgs_host_model

`default_nettype wire

// *** sim/bgs_gauge_top_tb.sv ***
// Purpose: self-checking bench of the gauge
// Assumes: host model drives the bus
// Notes:   every scenario is its own task
`timescale 1ns/1ps
`default_nettype none

`include "bgs_map.svh"

module bgs_gauge_top_tb;
    logic        clk_sys = 1'h0;
    logic        resetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [11:0] vbat_code = 12'hFFF, vsr_code = 12'h000;
    logic        charge_active = 1'h0, charge_fast = 1'h0, batt_valid = 1'h1;
    logic        nac_up = 1'h0, nac_down = 1'h0, display_mode_pin = 1'h0;
    logic [2:0]  dsg_rate = 3'h0;
    logic [3:0]  temp_step = 4'h5, gauge_step;
    logic        pfc_pu_sense = 1'h1, pfc_pd_sense = 1'h1;
    logic        overload, empty_voltage_flag;
    int          n_fail = 0;
    int          n_checks = 0;

    always #2.5 clk_sys = ~clk_sys;

    bgs_gauge_top i_dut (.clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .vbat_code, .vsr_code, .charge_active, .charge_fast,
        .dsg_rate, .batt_valid, .temp_step, .nac_up, .nac_down,
        .pfc_pu_sense, .pfc_pd_sense, .display_mode_pin, .gauge_step,
        .overload, .empty_voltage_flag);

    bgs_host_model i_host (.clk_sys, .hsel, .haddr, .htrans, .hwrite,
        .hwdata, .hready(hreadyout), .hrdata);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, s);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_host.access(1'h1, a, d, q);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_host.access(1'h0, a, 32'h0, q);
        chk($sformatf("reg %h", a), e, q);
    endtask : rc

    task automatic f1(input int b, input logic e);
        logic [31:0] q;
        i_host.access(1'h0, `BGS_OFS_FLAG_ONE, 32'h0, q);
        chk($sformatf("flag %0d", b), 32'(e), 32'(q[b]));
    endtask : f1

    task automatic pulse(input logic up);
        nac_up <= up;
        nac_down <= !up;
        tick(1);
        nac_up <= 1'h0;
        nac_down <= 1'h0;
    endtask : pulse

    task automatic pin_case(input logic pu, pd, dm, input logic [31:0] e);
        pfc_pu_sense <= pu;
        pfc_pd_sense <= pd;
        display_mode_pin <= dm;
        wr(`BGS_OFS_CMD, 32'h1);
        tick(2);
        rc(`BGS_OFS_PROG, e);
    endtask : pin_case

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rc(`BGS_OFS_LFD, 32'h40);
        rc(`BGS_OFS_EDV_TH, 32'h300);
        rc(`BGS_OFS_FIRST_EMPTY_THRESHOLD_TH, 32'h320);
        rc(`BGS_OFS_OVL_TH, 32'h200);
        rc(`BGS_OFS_BATT_ID, 32'h05);
        wr(`BGS_OFS_BATT_ID, 32'hFF);
        rc(`BGS_OFS_BATT_ID, 32'hFF);
        wr(8'h40, 32'h5A);
        rc(8'h40, 32'h0);
        wr(`BGS_OFS_FULLCNT, 32'h7);
        rc(`BGS_OFS_FULLCNT, 32'h0);
        rc(`BGS_OFS_CMD, 32'h0);
    endtask : t_regs

    task automatic t_empty();
        vbat_code <= 12'h100;
        tick(2);
        chk("empty", 32'h1, 32'(empty_voltage_flag));
        f1(`BGS_F1_EDV, 1'h1);
        vbat_code <= 12'hFFF;
        tick(3);
        chk("empty", 32'h1, 32'(empty_voltage_flag));
        charge_active <= 1'h1;
        tick(2);
        chk("empty", 32'h0, 32'(empty_voltage_flag));
        f1(`BGS_F1_CHG, 1'h1);
        charge_active <= 1'h0;
    endtask : t_empty

    task automatic t_removal();
        batt_valid <= 1'h0;
        tick(2);
        f1(`BGS_F1_BRM, 1'h1);
        batt_valid <= 1'h1;
        tick(2);
        f1(`BGS_F1_BRM, 1'h0);
        f1(`BGS_F1_BRP, 1'h1);
    endtask : t_removal

    task automatic t_full();
        wr(`BGS_OFS_NAC, 32'h3F);
        pulse(1'h1);
        f1(`BGS_F1_VDQ, 1'h1);
        f1(`BGS_F1_BRP, 1'h0);
        rc(`BGS_OFS_CICNT, 32'h1);
        rc(`BGS_OFS_FULLCNT, 32'h0);
        pulse(1'h0);
        tick(1);
        pulse(1'h1);
        rc(`BGS_OFS_FULLCNT, 32'h1);
        rc(`BGS_OFS_CICNT, 32'h0);
        wr(`BGS_OFS_NAC, 32'h20);
        f1(`BGS_F1_VDQ, 1'h0);
        rc(`BGS_OFS_TMPGAUGE, 32'h58);
        chk("gauge", 32'h8, 32'(gauge_step));
        wr(`BGS_OFS_NAC, 32'h0);
        tick(2);
        chk("gauge", 32'h0, 32'(gauge_step));
    endtask : t_full

    task automatic t_inaccurate();
        for (int i = 0; i < 63; i++)
        begin
            wr(`BGS_OFS_NAC, 32'h3F);
            pulse(1'h1);
        end
        rc(`BGS_OFS_CICNT, 32'd63);
        f1(`BGS_F1_CI, 1'h0);
        wr(`BGS_OFS_NAC, 32'h3F);
        pulse(1'h1);
        rc(`BGS_OFS_CICNT, 32'h40);
        f1(`BGS_F1_CI, 1'h1);
    endtask : t_inaccurate

    task automatic t_pins();
        pfc_pu_sense <= 1'h0;
        pfc_pd_sense <= 1'h0;
        tick(2);
        rc(`BGS_OFS_PROG, 32'h2);
        pin_case(1'h0, 1'h0, 1'h1, 32'h4);
        f1(`BGS_F1_BRP, 1'h1);
        f1(`BGS_F1_CI, 1'h0);
        rc(`BGS_OFS_NAC, 32'h0);
        pin_case(1'h1, 1'h0, 1'h1, 32'h5);
        wr(`BGS_OFS_NAC, 32'h40);
        tick(2);
        chk("gauge", 32'h8, 32'(gauge_step));
        pin_case(1'h1, 1'h1, 1'h0, 32'h2);
        wr(`BGS_OFS_NAC, 32'h40);
        tick(2);
        chk("gauge", 32'hF, 32'(gauge_step));
    endtask : t_pins

    task automatic t_overload();
        vsr_code <= 12'h201;
        charge_fast <= 1'h1;
        dsg_rate <= 3'h5;
        tick(2);
        chk("overload", 32'h1, 32'(overload));
        rc(`BGS_OFS_FLAG_TWO, 32'hD1);
        vsr_code <= 12'h200;
        charge_fast <= 1'h0;
        tick(2);
        chk("overload", 32'h0, 32'(overload));
        rc(`BGS_OFS_FLAG_TWO, 32'h50);
    endtask : t_overload

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        resetn = 1'h0;
        tick(6);
        resetn <= 1'h1;
        tick(2);
        t_regs();
        t_empty();
        t_removal();
        t_full();
        t_inaccurate();
        t_pins();
        t_overload();
        complete_run();
    end
endmodule : bgs_gauge_top_tb

`default_nettype wire
